// ---- design/odtc_cfg.svh ----
// Summary of operation
// - Clearing the DLL enable bit selects asynchronous termination control.
// - Asynchronous mode follows the ODT input directly, bypassing the DODTL delay line.
// - Asynchronous turn-on leaves park and reaches nominal in a window after ODT high.
// - Asynchronous turn-off is timed from the edge ODT is first registered low.
// - With buffer disable set, nominal termination is never applied in power-down.
// - ODT sampled after CKE low, or within tANPD before, may give nominal or park.
// - tANPD equals write latency minus one, counted back from power-down entry.
// - Synchronous and dynamic changes start at the latency's ending edge, settle in tADC.
// - The nominal value comes from mode register 1 bits 10 to 8.
// - Write termination is unused in DLL-off mode; its field must read 000.
`ifndef ODTC_CFG_SVH
`define ODTC_CFG_SVH
`define ODTC_ADDR_MR1 12'h000
`define ODTC_ADDR_MR2 12'h004
`define ODTC_ADDR_MR5 12'h008
`define ODTC_ADDR_LAT 12'h00c
`define ODTC_ADDR_STAT 12'h010
`define ODTC_MR1_DLL_BIT 0
`define ODTC_MR1_NOM_LSB 8
`define ODTC_MR2_WR_LSB 9
`define ODTC_MR5_BUFDIS_BIT 5
`define ODTC_MR5_PARK_LSB 6
`define ODTC_LAT_WL_LSB 0
`define ODTC_LAT_DODT_LSB 8
`define ODTC_MR1_RESET 32'h00000001
`define ODTC_MR2_RESET 32'h00000000
`define ODTC_MR5_RESET 32'h00000000
`define ODTC_LAT_RESET 32'h00000907
`define ODTC_AONAS_NS 1
`define ODTC_AONAS_MAX_NS 9
`define ODTC_AOFAS_NS 1
`define ODTC_AOFAS_MAX_NS 9
`define ODTC_CLK_NS 10
`endif

// ---- design/odtc_pkg.sv ----
package odtc_pkg;
    typedef enum logic [2:0] {
        ODTC_PARK = 3'b001,
        ODTC_SWITCH = 3'b010,
        ODTC_NOM = 3'b100
    } odtc_term_t;
endpackage

// ---- design/odtc_delay.sv ----
`timescale 1ns/1ps
// Programmable delay line for the synchronous ODT request.
module odtc_delay #(
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request
    input wire logic din,
    input wire logic [7:0] lat,
    output logic dout
);
    logic [DEPTH-1:0] shiftReg;
    logic [DEPTH-1:0] shiftNext;
    logic outReg;
    logic outNext;

    always_comb begin
        shiftNext = {shiftReg[DEPTH-2:0], din};
        if (lat == 8'h00) begin
            outNext = din;
        end else if (lat >= 8'(DEPTH)) begin
            outNext = shiftReg[DEPTH-1];
        end else begin
            outNext = shiftReg[lat[4:0] - 5'h01];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            shiftReg <= '0;
            outReg <= 1'b0;
        end else begin
            shiftReg <= shiftNext;
            outReg <= outNext;
        end
    end

    assign dout = outReg;
endmodule // odtc_delay

// ---- design/odtc_top.sv ----
`timescale 1ns/1ps
`include "odtc_cfg.svh"
module odtc_top
    import odtc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Memory link pins, synchronous to clk
    input wire logic odtPin,
    input wire logic ckePin,
    // Termination state
    output logic [2:0] rttSel,
    output logic rttNomOn,
    output logic rttSwitching,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int AON_MIN = (`ODTC_AONAS_NS + `ODTC_CLK_NS - 1) / `ODTC_CLK_NS;
    localparam int AON_SPAN = `ODTC_AONAS_MAX_NS / `ODTC_CLK_NS;
    localparam logic [3:0] SWITCH_CYC = 4'((AON_SPAN > AON_MIN) ? AON_SPAN : AON_MIN);

    function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus.

    logic [31:0] mr1Reg, mr1Next, mr2Reg, mr2Next, mr5Reg, mr5Next, latReg, latNext;
    logic [11:0] awAddrReg, awAddrNext;
    logic awHeldReg, awHeldNext;
    logic [31:0] wDataReg, wDataNext;
    logic [3:0] wStrbReg, wStrbNext;
    logic wHeldReg, wHeldNext;
    logic bValidReg, bValidNext;
    logic [1:0] bRespReg, bRespNext;
    logic rValidReg, rValidNext;
    logic [31:0] rDataReg, rDataNext;
    logic [1:0] rRespReg, rRespNext;
    logic [31:0] statWord;

    assign s_axi_awready = !awHeldReg && !bValidReg;
    assign s_axi_wready = !wHeldReg && !bValidReg;
    assign s_axi_arready = !rValidReg;
    assign s_axi_bvalid = bValidReg;
    assign s_axi_bresp = bRespReg;
    assign s_axi_rvalid = rValidReg;
    assign s_axi_rdata = rDataReg;
    assign s_axi_rresp = rRespReg;

    always_comb begin
        mr1Next = mr1Reg;
        mr2Next = mr2Reg;
        mr5Next = mr5Reg;
        latNext = latReg;
        awAddrNext = awAddrReg;
        awHeldNext = awHeldReg;
        wDataNext = wDataReg;
        wStrbNext = wStrbReg;
        wHeldNext = wHeldReg;
        bValidNext = bValidReg;
        bRespNext = bRespReg;
        rValidNext = rValidReg;
        rDataNext = rDataReg;
        rRespNext = rRespReg;
        if (s_axi_awvalid && s_axi_awready) begin
            awAddrNext = s_axi_awaddr;
            awHeldNext = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wDataNext = s_axi_wdata;
            wStrbNext = s_axi_wstrb;
            wHeldNext = 1'b1;
        end
        if (awHeldReg && wHeldReg) begin
            awHeldNext = 1'b0;
            wHeldNext = 1'b0;
            bValidNext = 1'b1;
            bRespNext = 2'b00;
            unique case (awAddrReg & 12'hffc)
                `ODTC_ADDR_MR1: mr1Next = strbMerge(mr1Reg, wDataReg, wStrbReg);
                `ODTC_ADDR_MR2: mr2Next = strbMerge(mr2Reg, wDataReg, wStrbReg);
                `ODTC_ADDR_MR5: mr5Next = strbMerge(mr5Reg, wDataReg, wStrbReg);
                `ODTC_ADDR_LAT: latNext = strbMerge(latReg, wDataReg, wStrbReg);
                `ODTC_ADDR_STAT: bRespNext = 2'b00;
                default: bRespNext = 2'b10;
            endcase
        end else if (bValidReg && s_axi_bready) begin
            bValidNext = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rValidNext = 1'b1;
            rRespNext = 2'b00;
            unique case (s_axi_araddr & 12'hffc)
                `ODTC_ADDR_MR1: rDataNext = mr1Reg;
                `ODTC_ADDR_MR2: rDataNext = mr2Reg;
                `ODTC_ADDR_MR5: rDataNext = mr5Reg;
                `ODTC_ADDR_LAT: rDataNext = latReg;
                `ODTC_ADDR_STAT: rDataNext = statWord;
                default: begin
                    rDataNext = 32'h00000000;
                    rRespNext = 2'b10;
                end
            endcase
        end else if (rValidReg && s_axi_rready) begin
            rValidNext = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mr1Reg <= `ODTC_MR1_RESET;
            mr2Reg <= `ODTC_MR2_RESET;
            mr5Reg <= `ODTC_MR5_RESET;
            latReg <= `ODTC_LAT_RESET;
            awAddrReg <= 12'h000;
            awHeldReg <= 1'b0;
            wDataReg <= 32'h00000000;
            wStrbReg <= 4'h0;
            wHeldReg <= 1'b0;
            bValidReg <= 1'b0;
            bRespReg <= 2'b00;
            rValidReg <= 1'b0;
            rDataReg <= 32'h00000000;
            rRespReg <= 2'b00;
        end else begin
            mr1Reg <= mr1Next;
            mr2Reg <= mr2Next;
            mr5Reg <= mr5Next;
            latReg <= latNext;
            awAddrReg <= awAddrNext;
            awHeldReg <= awHeldNext;
            wDataReg <= wDataNext;
            wStrbReg <= wStrbNext;
            wHeldReg <= wHeldNext;
            bValidReg <= bValidNext;
            bRespReg <= bRespNext;
            rValidReg <= rValidNext;
            rDataReg <= rDataNext;
            rRespReg <= rRespNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode.

    logic asyncMode;
    logic bufDisable;
    logic [2:0] nomCode, parkCode, wrCode;
    logic [7:0] wlCyc, dodtCyc;
    logic wrConflict;

    assign asyncMode = !mr1Reg[`ODTC_MR1_DLL_BIT];
    assign bufDisable = mr5Reg[`ODTC_MR5_BUFDIS_BIT];
    assign nomCode = mr1Reg[`ODTC_MR1_NOM_LSB +: 3];
    assign parkCode = mr5Reg[`ODTC_MR5_PARK_LSB +: 3];
    assign wrCode = mr2Reg[`ODTC_MR2_WR_LSB +: 3];
    assign wlCyc = latReg[`ODTC_LAT_WL_LSB +: 8];
    assign dodtCyc = latReg[`ODTC_LAT_DODT_LSB +: 8];
    // Software error flag: write termination left on while the DLL is off.
    assign wrConflict = asyncMode && (wrCode != 3'b000);

    ////////////////////////////////////////////////////////////////////////////////
    // Power-down tracking and termination state.

    logic ckeReg, pdReg, pdNext;
    logic syncReq;
    logic termReq;
    odtc_term_t stReg, stNext;
    logic [3:0] cntReg, cntNext;

    // Synchronous requests start on the edge ending DODTLon or DODTLoff.
    odtc_delay #(.DEPTH(32)) syncPath (
        .clk(clk),
        .rst(rst),
        .din(odtPin),
        .lat(dodtCyc),
        .dout(syncReq)
    );

    // Entry is taken on the edge CKE is first registered low; the host keeps ODT
    // steady through tCPDED, so gating with pdReg or a low ckePin is safe.
    always_comb begin
        pdNext = pdReg;
        if (ckeReg && !ckePin) begin
            pdNext = 1'b1;
        end else if (!ckeReg && ckePin) begin
            pdNext = 1'b0;
        end
    end

    // Samples inside tANPD (WL-1) may resolve to park here: treated as allowed.
    assign termReq = (asyncMode ? odtPin : syncReq)
                     && !(bufDisable && (pdReg || !ckePin));

    always_comb begin
        stNext = stReg;
        cntNext = cntReg;
        unique case (stReg)
            ODTC_PARK: begin
                if (termReq) begin
                    stNext = asyncMode ? ODTC_SWITCH : ODTC_NOM;
                    cntNext = SWITCH_CYC;
                end
            end
            ODTC_SWITCH: begin
                if (!termReq) begin
                    stNext = ODTC_PARK;
                end else if (cntReg <= 4'h1) begin
                    stNext = ODTC_NOM;
                end else begin
                    cntNext = cntReg - 4'h1;
                end
            end
            ODTC_NOM: begin
                if (!termReq) begin
                    stNext = ODTC_PARK;
                end
            end
            default: stNext = ODTC_PARK;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ckeReg <= 1'b1;
            pdReg <= 1'b0;
            stReg <= ODTC_PARK;
            cntReg <= 4'h0;
        end else begin
            ckeReg <= ckePin;
            pdReg <= pdNext;
            stReg <= stNext;
            cntReg <= cntNext;
        end
    end

    // The rttSel code is registered so the pad driver sees a clean code.
    logic [2:0] selReg, selNext;
    always_comb begin
        selNext = (stNext == ODTC_NOM) ? nomCode : parkCode;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            selReg <= 3'b000;
        end else begin
            selReg <= selNext;
        end
    end

    assign rttSel = selReg;
    assign rttNomOn = (stReg == ODTC_NOM);
    assign rttSwitching = (stReg == ODTC_SWITCH);
    assign statWord = {25'h0000000, wlCyc[2:0] == 3'b000, wrConflict, pdReg, stReg, asyncMode};
endmodule // odtc_top

// ---- dv/odtc_host.sv ----
`timescale 1ns/1ps
module odtc_host #(
    parameter int HOLD = 10,
    parameter int CPDED = 4,
    parameter int XP = 6
) (
    // Clock
    input logic clk,
    // Link pins
    output logic odtPin,
    output logic ckePin
);
    initial begin
        odtPin = 1'h0;
        ckePin = 1'h1;
    end
    task automatic set_odt(input logic v);
        odtPin <= v;
    endtask
    ////////////////////////////////
    // HOLD covers tDODToff+1 and also the WL-1 span before entry.
    task automatic power_down(input int n);
        repeat (HOLD) @(posedge clk);
        ckePin <= 1'h0;
        repeat (CPDED) @(posedge clk);
        // A released line has no pull, so it shows a changing level.
        repeat (n) begin
            odtPin <= ~odtPin;
            @(posedge clk);
        end
        ckePin <= 1'h1;
        odtPin <= 1'h0;
        repeat (XP) @(posedge clk);
    endtask
endmodule // odtc_host

// ---- dv/odtc_chk_asserts.sv ----
`timescale 1ns/1ps
`include "odtc_cfg.svh"
module odtc_chk (
    // Clock and reset
    input logic clk,
    input logic rst,
    // Link and termination
    input logic odtPin,
    input logic ckePin,
    input logic [2:0] rttSel,
    input logic rttNomOn,
    input logic rttSwitching,
    // Register bus
    input logic [11:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid
);
    // Mirror of the mode fields; byte-strobed writes would put it out of step.
    logic [11:0] addrReg;
    logic [31:0] dataReg;
    logic dllOn, bufDis;
    logic [2:0] nomCode, parkCode;
    always_ff @(posedge clk) begin
        if (s_axi_awvalid && s_axi_awready) addrReg <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) dataReg <= s_axi_wdata;
        if (rst) begin
            dllOn <= 1'h1;
            bufDis <= 1'h0;
            nomCode <= 3'h0;
            parkCode <= 3'h0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            if (addrReg == `ODTC_ADDR_MR1) begin
                dllOn <= dataReg[`ODTC_MR1_DLL_BIT];
                nomCode <= dataReg[`ODTC_MR1_NOM_LSB +: 3];
            end
            if (addrReg == `ODTC_ADDR_MR5) begin
                bufDis <= dataReg[`ODTC_MR5_BUFDIS_BIT];
                parkCode <= dataReg[`ODTC_MR5_PARK_LSB +: 3];
            end
        end
    end
    ////////////////////////////////
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    chk_async_on: assert property (
        !dllOn && ckePin && $rose(odtPin) |=> rttSwitching ##1 rttNomOn)
        else $error("async turn-on window wrong");
    chk_async_off: assert property (
        !dllOn && $fell(odtPin) |=> !rttNomOn && !rttSwitching)
        else $error("async turn-off late");
    chk_sel_code: assert property (
        !s_axi_bvalid |-> rttSel == (rttNomOn ? nomCode : parkCode))
        else $error("termination code wrong");
    chk_pd_block: assert property (
        (bufDis && !ckePin) [*3] |-> !rttNomOn)
        else $error("nominal applied in power-down");
    chk_switch_once: assert property (
        rttSwitching |-> !dllOn ##1 !rttSwitching)
        else $error("switch window wrong");
    chk_sync_on: assert property (
        dllOn && ckePin && $rose(odtPin) |-> ##[2:20] rttNomOn)
        else $error("sync turn-on missing");
    chk_sync_hold: assert property (
        dllOn && $rose(odtPin) |=> !rttNomOn [*8])
        else $error("sync turn-on early");
    chk_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_wr_lat: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    cov_switch: cover property ($rose(rttSwitching));
    cov_pd: cover property (bufDis && !ckePin);
    cov_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // odtc_chk
bind odtc_top odtc_chk u_chk (.*);

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`include "odtc_cfg.svh"
module testbench;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic odtPin, ckePin, rttNomOn, rttSwitching, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [2:0] rttSel, nom, park;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    int error_cnt = 0, checks_done = 0, seed = 25878, sw, nm;
    logic [11:0] ra[6] = '{`ODTC_ADDR_MR1, `ODTC_ADDR_MR2, `ODTC_ADDR_MR5,
        `ODTC_ADDR_LAT, `ODTC_ADDR_STAT, 12'h100};
    logic [31:0] rv[6] = '{`ODTC_MR1_RESET, `ODTC_MR2_RESET, `ODTC_MR5_RESET,
        `ODTC_LAT_RESET, 32'h2, 32'h0};
    odtc_top u_dut (
        .clk(clk),
        .rst(rst),
        .odtPin(odtPin),
        .ckePin(ckePin),
        .rttSel(rttSel),
        .rttNomOn(rttNomOn),
        .rttSwitching(rttSwitching),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );
    odtc_host u_host (.clk(clk), .odtPin(odtPin), .ckePin(ckePin));
    always #5 clk = ~clk;
    // The run needs about 300 cycles; the 20000-cycle limit, over sixty times that, means a hang.
    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end
    ////////////////////////////////
    function automatic logic [31:0] mr1_val(logic [2:0] c, logic dll);
        return {21'h0, c, 7'h0, dll};
    endfunction
    function automatic logic [31:0] mr5_val(logic [2:0] c, logic dis);
        return {23'h0, c, dis, 5'h0};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw, w, b;
        int n;
        aw = 1'h1;
        w = 1'h1;
        b = 1'h1;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (b && n < 100) begin
            @(posedge clk);
            n++;
            if (aw && s_axi_awready) begin
                aw = 1'h0;
                s_axi_awvalid <= 1'h0;
            end
            if (w && s_axi_wready) begin
                w = 1'h0;
                s_axi_wvalid <= 1'h0;
            end
            if (!aw && !w && s_axi_bvalid) begin
                b = 1'h0;
                rr = s_axi_bresp;
                s_axi_bready <= 1'h0;
            end
        end
        chk(b, 1'h0);
        @(posedge clk);
    endtask
    task automatic axr(input logic [11:0] a);
        logic ar, r;
        int n;
        ar = 1'h1;
        r = 1'h1;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (r && n < 100) begin
            @(posedge clk);
            n++;
            if (!ar && s_axi_rvalid) begin
                r = 1'h0;
                rd = s_axi_rdata;
                rr = s_axi_rresp;
                s_axi_rready <= 1'h0;
            end
            if (ar && s_axi_arready) begin
                ar = 1'h0;
                s_axi_arvalid <= 1'h0;
            end
        end
        chk(r, 1'h0);
        @(posedge clk);
    endtask
    task automatic wait_nom(input logic v);
        int n;
        n = 0;
        while (rttNomOn !== v && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk(rttNomOn, v);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////
    initial begin
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        s_axi_bready <= 1'h0;
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h0;
        s_axi_awaddr <= 12'h000;
        s_axi_araddr <= 12'h000;
        s_axi_wdata <= 32'h00000000;
        s_axi_wstrb <= 4'hf;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        chk(rttSel, 3'h0);
        for (int i = 0; i < 6; i++) begin
            axr(ra[i]);
            chk(rd, rv[i]);
            chk(rr, (i == 5) ? 2'h2 : 2'h0);
        end
        axw(12'h100, 32'h1, 4'hf);
        chk(rr, 2'h2);
        // Only the low byte lane is enabled, so the DODT latency byte must survive.
        axw(`ODTC_ADDR_LAT, 32'hffffff08, 4'h1);
        axr(`ODTC_ADDR_LAT);
        chk(rd, 32'h00000908);
        axr(`ODTC_ADDR_STAT);
        chk(rd, 32'h00000042);
        $display("register test done");
        for (int i = 0; i < 4; i++) begin
            nom = 3'($random(seed));
            park = 3'($random(seed));
            axw(`ODTC_ADDR_MR1, mr1_val(nom, 1'h1), 4'hf);
            axw(`ODTC_ADDR_MR5, mr5_val(park, 1'h0), 4'hf);
            axr(`ODTC_ADDR_MR1);
            chk(rd & 32'h701, mr1_val(nom, 1'h1));
            u_host.set_odt(1'h1);
            wait_nom(1'h1);
            chk(rttSel, nom);
            u_host.set_odt(1'h0);
            wait_nom(1'h0);
            chk(rttSel, park);
            repeat (4) @(posedge clk);
        end
        $display("sync test done");
        axw(`ODTC_ADDR_MR2, 32'h00000200, 4'hf);
        axw(`ODTC_ADDR_MR1, mr1_val(nom, 1'h0), 4'hf);
        axr(`ODTC_ADDR_STAT);
        chk(rd[0], 1'h1);
        chk(rd[5], 1'h1);
        axw(`ODTC_ADDR_MR2, 32'h0, 4'hf);
        axr(`ODTC_ADDR_STAT);
        chk(rd[5], 1'h0);
        for (int i = 0; i < 4; i++) begin
            u_host.set_odt(1'h1);
            sw = 0;
            nm = 0;
            for (int k = 1; k <= 5; k++) begin
                @(posedge clk);
                if (rttSwitching === 1'h1 && sw == 0) sw = k;
                if (rttNomOn === 1'h1 && nm == 0) nm = k;
            end
            chk(sw, 2);
            chk(nm, 3);
            u_host.set_odt(1'h0);
            @(posedge clk);
            chk(rttNomOn, 1'h1);
            @(posedge clk);
            chk(rttNomOn, 1'h0);
            repeat (2 + ($random(seed) & 3)) @(posedge clk);
        end
        $display("async test done");
        axw(`ODTC_ADDR_MR5, mr5_val(park, 1'h1), 4'hf);
        u_host.set_odt(1'h1);
        wait_nom(1'h1);
        fork
            u_host.power_down(20);
            begin
                repeat (20) @(posedge clk);
                axr(`ODTC_ADDR_STAT);
                chk(rd[4], 1'h1);
                chk(rttNomOn, 1'h0);
            end
        join
        chk(rttNomOn, 1'h0);
        chk(rttSel, park);
        $display("power-down test done");
        end_sim();
    end
endmodule // testbench
